// File: hdl/bbce_params.svh
`ifndef BBCE_PARAMS_SVH
`define BBCE_PARAMS_SVH

// ---------------------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------------------
`define BBCE_ADDR_W 8
`define BBCE_OFF_CLKSEL 8'h00
`define BBCE_OFF_STATUS 8'h04
`define BBCE_OFF_PSW 8'h08
`define BBCE_CLKSEL_RST 3'h0
`define BBCE_CLKSEL_MAX 3'h4
`define BBCE_PSW_RST 8'h00

// ---------------------------------------------------------------------------
// Status word fields
// ---------------------------------------------------------------------------
`define BBCE_PSW_IE 7
`define BBCE_PSW_Z 6
`define BBCE_PSW_RBS1 5
`define BBCE_PSW_AC 4
`define BBCE_PSW_RBS0 3
`define BBCE_PSW_CY 0

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define BBCE_ST_PSW_LSB 0
`define BBCE_ST_BUSY 8
`define BBCE_ST_HALT 9
`define BBCE_ST_STOP 10

// ---------------------------------------------------------------------------
// Instruction lengths in bytes
// ---------------------------------------------------------------------------
`define BBCE_LEN_1 16'h0001
`define BBCE_LEN_2 16'h0002
`define BBCE_LEN_3 16'h0003
`define BBCE_LEN_4 16'h0004

// ---------------------------------------------------------------------------
// Instruction clock counts
// ---------------------------------------------------------------------------
`define BBCE_CYC_2 8'h02
`define BBCE_CYC_4 8'h04
`define BBCE_CYC_6 8'h06
`define BBCE_CYC_8 8'h08
`define BBCE_CYC_9 8'h09
`define BBCE_CYC_10 8'h0A
`define BBCE_CYC_11 8'h0B
`define BBCE_CYC_12 8'h0C

`endif

// File: hdl/bbce_pkg.sv
package bbce_pkg;

	typedef enum logic [3:0] {
		OP_JUMP_IF_SET,
		OP_JUMP_IF_CLEAR,
		OP_JUMP_SET_AND_CLEAR,
		OP_DECREMENT_JUMP_NONZERO,
		OP_BANK_SWITCH,
		OP_IDLE,
		OP_UNMASK_INTERRUPTS,
		OP_MASK_INTERRUPTS,
		OP_HALT,
		OP_STOP
	} bbce_op_t;

	typedef enum logic [2:0] {
		SP_SHORT_DIRECT,
		SP_PERIPHERAL,
		SP_ACCUMULATOR,
		SP_STATUS_WORD,
		SP_POINTER_PAIR,
		SP_GENERAL_REG
	} bbce_space_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_STANDBY
	} bbce_state_t;

endpackage

// File: hdl/bbce_tick_if.sv
`timescale 1ns/100ps

interface bbce_tick_if;
	logic [2:0] clock_select;
	logic tick;

	modport divider (
		input clock_select,
		output tick
	);

	modport core (
		output clock_select,
		input tick
	);
endinterface

// File: hdl/bbce_tick_div.sv
`timescale 1ns/100ps

// The instruction clock is a one-cycle enable at clk divided by 2 to the power of the selection.
module bbce_tick_div (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core side
	bbce_tick_if.divider tk
);

	logic [3:0] cnt_r;
	logic [3:0] mask;

	assign mask = 4'hF >> (3'h4 - tk.clock_select);
	assign tk.tick = ((cnt_r & mask) == mask);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

endmodule // bbce_tick_div

// File: hdl/bbce_exec.sv
`timescale 1ns/100ps
`include "bbce_params.svh"

// Behaviour
// - jump_if_set branches by length plus offset on a set bit; 3 bytes, 4 peripheral.
// - jump_if_clear branches on a clear bit; 4 bytes, 3 for accumulator and pointer_pair.
// - jump_set_and_clear branches and clears a set bit; clear bit leaves bit untouched.
// - Clearing a status word bit alters flags; status word form takes 12 clocks.
// - Register decrement_jump_nonzero decrements, branches if nonzero, 2 bytes, 6 clocks.
// - Short direct decrement_jump_nonzero writes back, branches if nonzero; 8 or 10 clocks.
// - unmask_interrupts_op sets interrupt_enable in 6 clocks.
// - mask_interrupts_op clears interrupt_enable in 6 clocks.
// - One instruction clock is one period of the selected core clock rate.
// - Pointer_pair bit test takes 10 clocks in fast RAM, else 11 plus read waits.
// - Pointer_pair set-and-clear outside fast RAM takes 12 plus read and write waits.
// - Operands outside fast RAM use the longer clock count.
// - Counts hold for internal ROM; other fetch sources add fetch waits.
module bbce_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [`BBCE_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Decoded instruction
	input wire logic instr_valid,
	output logic instr_ready,
	input wire bbce_pkg::bbce_op_t instr_op,
	input wire bbce_pkg::bbce_space_t instr_space,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_offset,
	input wire logic [1:0] instr_bank,
	input wire logic [15:0] instr_pc,
	input wire logic instr_fast_ram,
	input wire logic instr_from_rom,
	input wire logic [3:0] fetch_waits,
	input wire logic [3:0] read_waits,
	input wire logic [3:0] write_waits,
	input wire logic [7:0] operand_rdata,
	// Results
	output logic done,
	output logic [15:0] next_pc,
	output logic branch_taken,
	output logic operand_wr,
	output logic [7:0] operand_wdata,
	output logic [7:0] status_word,
	output logic interrupt_enable,
	output logic [1:0] bank_select_bits,
	// Standby
	input wire logic wake,
	output logic halt_mode,
	output logic stop_mode
);

	// -----------------------------------------------------------------------
	// Lookup functions
	// -----------------------------------------------------------------------

	function automatic logic [15:0] instr_len(bbce_pkg::bbce_op_t op,
			bbce_pkg::bbce_space_t sp);
		logic short3;
		short3 = (sp == bbce_pkg::SP_ACCUMULATOR) || (sp == bbce_pkg::SP_POINTER_PAIR);
		case (op)
			bbce_pkg::OP_JUMP_IF_SET: begin
				instr_len = (sp == bbce_pkg::SP_PERIPHERAL) ? `BBCE_LEN_4 : `BBCE_LEN_3;
			end
			bbce_pkg::OP_JUMP_IF_CLEAR, bbce_pkg::OP_JUMP_SET_AND_CLEAR: begin
				instr_len = short3 ? `BBCE_LEN_3 : `BBCE_LEN_4;
			end
			bbce_pkg::OP_DECREMENT_JUMP_NONZERO: begin
				instr_len = (sp == bbce_pkg::SP_GENERAL_REG) ? `BBCE_LEN_2 : `BBCE_LEN_3;
			end
			bbce_pkg::OP_IDLE: begin
				instr_len = `BBCE_LEN_1;
			end
			default: begin
				instr_len = `BBCE_LEN_2;
			end
		endcase
	endfunction

	function automatic logic [7:0] base_cycles(bbce_pkg::bbce_op_t op,
			bbce_pkg::bbce_space_t sp, logic fast);
		case (op)
			bbce_pkg::OP_JUMP_IF_SET, bbce_pkg::OP_JUMP_IF_CLEAR,
			bbce_pkg::OP_JUMP_SET_AND_CLEAR: begin
				case (sp)
					bbce_pkg::SP_ACCUMULATOR: begin
						base_cycles = `BBCE_CYC_8;
					end
					bbce_pkg::SP_POINTER_PAIR: begin
						if (fast) begin
							base_cycles = `BBCE_CYC_10;
						end else if (op == bbce_pkg::OP_JUMP_SET_AND_CLEAR) begin
							base_cycles = `BBCE_CYC_12;
						end else begin
							base_cycles = `BBCE_CYC_11;
						end
					end
					bbce_pkg::SP_SHORT_DIRECT: begin
						if (op == bbce_pkg::OP_JUMP_IF_SET) begin
							base_cycles = fast ? `BBCE_CYC_8 : `BBCE_CYC_9;
						end else if (op == bbce_pkg::OP_JUMP_IF_CLEAR) begin
							base_cycles = fast ? `BBCE_CYC_10 : `BBCE_CYC_11;
						end else begin
							base_cycles = fast ? `BBCE_CYC_10 : `BBCE_CYC_12;
						end
					end
					bbce_pkg::SP_STATUS_WORD: begin
						if (op == bbce_pkg::OP_JUMP_IF_SET) begin
							base_cycles = `BBCE_CYC_9;
						end else if (op == bbce_pkg::OP_JUMP_IF_CLEAR) begin
							base_cycles = `BBCE_CYC_11;
						end else begin
							base_cycles = `BBCE_CYC_12;
						end
					end
					default: begin
						base_cycles = (op == bbce_pkg::OP_JUMP_SET_AND_CLEAR) ?
							`BBCE_CYC_12 : `BBCE_CYC_11;
					end
				endcase
			end
			bbce_pkg::OP_DECREMENT_JUMP_NONZERO: begin
				if (sp == bbce_pkg::SP_GENERAL_REG) begin
					base_cycles = `BBCE_CYC_6;
				end else begin
					base_cycles = fast ? `BBCE_CYC_8 : `BBCE_CYC_10;
				end
			end
			bbce_pkg::OP_BANK_SWITCH: begin
				base_cycles = `BBCE_CYC_4;
			end
			bbce_pkg::OP_IDLE: begin
				base_cycles = `BBCE_CYC_2;
			end
			default: begin
				base_cycles = `BBCE_CYC_6;
			end
		endcase
	endfunction

	// -----------------------------------------------------------------------
	// Instruction clock
	// -----------------------------------------------------------------------

	bbce_tick_if tk ();
	logic [2:0] clksel_r;

	assign tk.clock_select = clksel_r;

	bbce_tick_div u_div (
		.clk(clk),
		.rst(rst),
		.tk(tk)
	);

	// -----------------------------------------------------------------------
	// Accept and cycle count
	// -----------------------------------------------------------------------

	bbce_pkg::bbce_state_t state_r;
	bbce_pkg::bbce_state_t state_nxt;
	bbce_pkg::bbce_op_t op_r;
	bbce_pkg::bbce_space_t space_r;
	logic [2:0] bit_r;
	logic [7:0] opnd_r;
	logic [1:0] bank_r;
	logic [15:0] target_r;
	logic [15:0] fall_r;
	logic [7:0] cnt_r;
	logic [7:0] psw_r;
	logic [15:0] len;
	logic [7:0] cycles;
	logic [7:0] extra_mem;
	logic [7:0] extra_fetch;
	logic accept;

	// Memory wait states only stretch pointer_pair accesses to the expansion area.
	assign extra_mem = (instr_space != bbce_pkg::SP_POINTER_PAIR || instr_fast_ram) ? 8'h00 :
		(instr_op == bbce_pkg::OP_JUMP_SET_AND_CLEAR) ?
		({4'h0, read_waits} + {4'h0, write_waits}) : {4'h0, read_waits};
	assign extra_fetch = instr_from_rom ? 8'h00 : {4'h0, fetch_waits};
	assign len = instr_len(instr_op, instr_space);
	assign cycles = base_cycles(instr_op, instr_space, instr_fast_ram) + extra_mem + extra_fetch;
	assign instr_ready = (state_r == bbce_pkg::ST_IDLE);
	assign accept = instr_valid && instr_ready;

	// -----------------------------------------------------------------------
	// Execution results
	// -----------------------------------------------------------------------

	logic [7:0] tested;
	logic bit_val;
	logic [7:0] cleared;
	logic [7:0] decr;
	logic take;
	logic last;
	logic finish;
	logic psw_target;

	assign psw_target = (space_r == bbce_pkg::SP_STATUS_WORD);
	assign tested = psw_target ? psw_r : opnd_r;
	assign bit_val = tested[bit_r];
	assign cleared = tested & ~(8'h01 << bit_r);
	assign decr = opnd_r - 8'h01;
	assign last = tk.tick && (cnt_r == 8'h01);
	assign finish = (state_r == bbce_pkg::ST_EXEC) && last;

	always_comb begin
		case (op_r)
			bbce_pkg::OP_JUMP_IF_SET, bbce_pkg::OP_JUMP_SET_AND_CLEAR: begin
				take = bit_val;
			end
			bbce_pkg::OP_JUMP_IF_CLEAR: begin
				take = !bit_val;
			end
			bbce_pkg::OP_DECREMENT_JUMP_NONZERO: begin
				take = (decr != 8'h00);
			end
			default: begin
				take = 1'b0;
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bbce_pkg::ST_IDLE: begin
				if (accept) begin
					state_nxt = bbce_pkg::ST_EXEC;
				end
			end
			bbce_pkg::ST_EXEC: begin
				if (last) begin
					if (op_r == bbce_pkg::OP_HALT || op_r == bbce_pkg::OP_STOP) begin
						state_nxt = bbce_pkg::ST_STANDBY;
					end else begin
						state_nxt = bbce_pkg::ST_IDLE;
					end
				end
			end
			bbce_pkg::ST_STANDBY: begin
				if (wake) begin
					state_nxt = bbce_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = bbce_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= bbce_pkg::ST_IDLE;
			op_r <= bbce_pkg::OP_IDLE;
			space_r <= bbce_pkg::SP_ACCUMULATOR;
			bit_r <= 3'h0;
			opnd_r <= 8'h00;
			bank_r <= 2'h0;
			target_r <= 16'h0000;
			fall_r <= 16'h0000;
			cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				op_r <= instr_op;
				space_r <= instr_space;
				bit_r <= instr_bit;
				opnd_r <= operand_rdata;
				bank_r <= instr_bank;
				fall_r <= instr_pc + len;
				target_r <= instr_pc + len + {{8{instr_offset[7]}}, instr_offset};
				cnt_r <= cycles;
			end else if (state_r == bbce_pkg::ST_EXEC && tk.tick) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Status word, operand write and completion outputs
	// -----------------------------------------------------------------------

	logic sw_psw;
	logic [7:0] psw_nxt;
	logic wr_back;

	assign sw_psw = reg_wr && (reg_addr == `BBCE_OFF_PSW);
	assign wr_back = finish && ((op_r == bbce_pkg::OP_JUMP_SET_AND_CLEAR && take && !psw_target)
		|| op_r == bbce_pkg::OP_DECREMENT_JUMP_NONZERO);

	always_comb begin
		psw_nxt = sw_psw ? reg_wdata[7:0] : psw_r;
		if (finish) begin
			case (op_r)
				bbce_pkg::OP_JUMP_SET_AND_CLEAR: begin
					if (take && psw_target) begin
						psw_nxt[bit_r] = 1'b0;
					end
				end
				bbce_pkg::OP_UNMASK_INTERRUPTS: begin
					psw_nxt[`BBCE_PSW_IE] = 1'b1;
				end
				bbce_pkg::OP_MASK_INTERRUPTS: begin
					psw_nxt[`BBCE_PSW_IE] = 1'b0;
				end
				bbce_pkg::OP_BANK_SWITCH: begin
					psw_nxt[`BBCE_PSW_RBS1] = bank_r[1];
					psw_nxt[`BBCE_PSW_RBS0] = bank_r[0];
				end
				default: begin
					psw_nxt = psw_nxt;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			psw_r <= `BBCE_PSW_RST;
			done <= 1'b0;
			next_pc <= 16'h0000;
			branch_taken <= 1'b0;
			operand_wr <= 1'b0;
			operand_wdata <= 8'h00;
			halt_mode <= 1'b0;
			stop_mode <= 1'b0;
		end else begin
			psw_r <= psw_nxt;
			done <= finish;
			operand_wr <= wr_back;
			if (finish) begin
				next_pc <= take ? target_r : fall_r;
				branch_taken <= take;
				operand_wdata <= (op_r == bbce_pkg::OP_DECREMENT_JUMP_NONZERO) ? decr : cleared;
			end
			if (finish && op_r == bbce_pkg::OP_HALT) begin
				halt_mode <= 1'b1;
			end else if (wake) begin
				halt_mode <= 1'b0;
			end
			if (finish && op_r == bbce_pkg::OP_STOP) begin
				stop_mode <= 1'b1;
			end else if (wake) begin
				stop_mode <= 1'b0;
			end
		end
	end

	assign status_word = psw_r;
	assign interrupt_enable = psw_r[`BBCE_PSW_IE];
	assign bank_select_bits = {psw_r[`BBCE_PSW_RBS1], psw_r[`BBCE_PSW_RBS0]};

	// -----------------------------------------------------------------------
	// Register port
	// -----------------------------------------------------------------------

	logic [31:0] rd_mux;
	logic [31:0] status_val;

	assign status_val = {21'h000000, stop_mode, halt_mode, !instr_ready, psw_r};
	assign rd_mux = (reg_addr == `BBCE_OFF_CLKSEL) ? {29'h00000000, clksel_r} :
		(reg_addr == `BBCE_OFF_STATUS) ? status_val :
		(reg_addr == `BBCE_OFF_PSW) ? {24'h000000, psw_r} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst) begin
			clksel_r <= `BBCE_CLKSEL_RST;
			reg_rdata <= 32'h00000000;
		end else begin
			// Selections past the slowest rate are clipped so the divider mask stays valid.
			if (reg_wr && reg_addr == `BBCE_OFF_CLKSEL) begin
				clksel_r <= (reg_wdata[2:0] > `BBCE_CLKSEL_MAX) ? `BBCE_CLKSEL_MAX :
					reg_wdata[2:0];
			end
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

endmodule // bbce_exec

// File: testbench/bbce_exec_properties.sv
`timescale 1ns/100ps
`include "bbce_params.svh"

module bbce_exec_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Stimulus seen
	input wire logic [`BBCE_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire bbce_pkg::bbce_op_t instr_op,
	input wire bbce_pkg::bbce_space_t instr_space,
	input wire logic [2:0] instr_bit,
	input wire logic [1:0] instr_bank,
	input wire logic [15:0] instr_pc,
	input wire logic instr_from_rom,
	input wire logic [7:0] operand_rdata,
	// Results seen
	input wire logic done,
	input wire logic [15:0] next_pc,
	input wire logic branch_taken,
	input wire logic [7:0] operand_wdata,
	input wire logic [7:0] status_word,
	input wire logic interrupt_enable,
	input wire logic [1:0] bank_select_bits,
	input wire logic halt_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Fixed delays only hold for an undivided clock, so track the clock select.
	logic sel0_r;
	wire go = instr_valid && instr_ready && instr_from_rom && sel0_r;
	wire acc_bit = operand_rdata[instr_bit];
	always_ff @(posedge clk) begin
		if (rst)
			sel0_r <= 1'b1;
		else if (reg_wr && reg_addr == `BBCE_OFF_CLKSEL)
			sel0_r <= reg_wdata[2:0] == 3'h0;
	end

	// ----------
	// Properties
	// ----------
	sequence s_idle_run;
		!done [*2] ##1 done;
	endsequence

	a_idle_len: assert property (go && instr_op == bbce_pkg::OP_IDLE |=>
		s_idle_run ##0 next_pc == $past(instr_pc, 3) + 16'h0001) else $error("idle wrong");
	a_unmask_ie: assert property (go && instr_op == bbce_pkg::OP_UNMASK_INTERRUPTS |->
		##7 (done && interrupt_enable)) else $error("unmask wrong");
	a_mask_ie: assert property (go && instr_op == bbce_pkg::OP_MASK_INTERRUPTS |->
		##7 (done && !interrupt_enable)) else $error("mask wrong");
	a_bank_bits: assert property (go && instr_op == bbce_pkg::OP_BANK_SWITCH |->
		##5 (done && bank_select_bits == $past(instr_bank, 5))) else $error("bank wrong");
	a_halt_enter: assert property (go && instr_op == bbce_pkg::OP_HALT |->
		##7 done ##1 halt_mode) else $error("halt wrong");
	a_dec_write: assert property (go && instr_op == bbce_pkg::OP_DECREMENT_JUMP_NONZERO &&
		instr_space == bbce_pkg::SP_GENERAL_REG |-> ##7
		(done && operand_wdata == $past(operand_rdata, 7) - 8'h01)) else $error("dec wrong");
	a_psw_clear: assert property (go && instr_op == bbce_pkg::OP_JUMP_SET_AND_CLEAR &&
		instr_space == bbce_pkg::SP_STATUS_WORD |-> ##13
		(done && !status_word[$past(instr_bit, 13)])) else $error("psw clear wrong");
	a_acc_test: assert property (go && instr_op == bbce_pkg::OP_JUMP_IF_SET &&
		instr_space == bbce_pkg::SP_ACCUMULATOR |-> ##9
		(done && branch_taken == $past(acc_bit, 9))) else $error("test wrong");
endmodule // bbce_exec_properties

bind bbce_exec bbce_exec_properties bbce_exec_properties_inst (.clk, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .instr_valid, .instr_ready, .instr_op, .instr_space, .instr_bit,
	.instr_bank, .instr_pc, .instr_from_rom, .operand_rdata, .done, .next_pc, .branch_taken,
	.operand_wdata, .status_word, .interrupt_enable, .bank_select_bits, .halt_mode);

// File: testbench/bbce_mem_model.sv
`timescale 1ns/100ps

// One operand byte: the bench loads it, the block reads it and writes it back.
module bbce_mem_model (
	// Clock
	input wire logic clk,
	// Bench load
	input wire logic load,
	input wire logic [7:0] load_data,
	// Block side
	input wire logic operand_wr,
	input wire logic [7:0] operand_wdata,
	output logic [7:0] operand_rdata
);
	always_ff @(posedge clk) begin
		if (load)
			operand_rdata <= load_data;
		else if (operand_wr)
			operand_rdata <= operand_wdata;
	end
endmodule // bbce_mem_model

// File: testbench/testbench.sv
`timescale 1ns/100ps
`include "bbce_params.svh"

module testbench;
	logic clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0, wake = 1'b0;
	logic [`BBCE_ADDR_W-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, rv;
	bbce_pkg::bbce_op_t instr_op = bbce_pkg::OP_IDLE;
	bbce_pkg::bbce_space_t instr_space = bbce_pkg::SP_SHORT_DIRECT;
	logic [2:0] instr_bit = '0;
	logic [7:0] instr_offset = 8'hF0, ld_data = '0, operand_rdata, operand_wdata, status_word;
	logic [1:0] instr_bank = 2'h2, bank_select_bits;
	logic [15:0] instr_pc = 16'h1000, next_pc;
	logic [3:0] fetch_waits = '0, read_waits = '0, write_waits = '0;
	logic instr_fast_ram = 1'b0, instr_from_rom = 1'b1, ld = 1'b0, instr_ready, done;
	logic branch_taken, operand_wr, interrupt_enable, halt_mode, stop_mode;
	int error_cnt, num_checks, cyc;
	localparam bbce_pkg::bbce_op_t JS = bbce_pkg::OP_JUMP_IF_SET;
	localparam bbce_pkg::bbce_op_t JC = bbce_pkg::OP_JUMP_IF_CLEAR;
	localparam bbce_pkg::bbce_op_t JX = bbce_pkg::OP_JUMP_SET_AND_CLEAR;
	localparam bbce_pkg::bbce_op_t DJ = bbce_pkg::OP_DECREMENT_JUMP_NONZERO;
	localparam bbce_pkg::bbce_op_t ID = bbce_pkg::OP_IDLE;
	localparam bbce_pkg::bbce_space_t SD = bbce_pkg::SP_SHORT_DIRECT;
	localparam bbce_pkg::bbce_space_t PP = bbce_pkg::SP_POINTER_PAIR;
	localparam bbce_pkg::bbce_space_t PS = bbce_pkg::SP_STATUS_WORD;

	bbce_exec bbce_exec_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.instr_valid, .instr_ready, .instr_op, .instr_space, .instr_bit, .instr_offset,
		.instr_bank, .instr_pc, .instr_fast_ram, .instr_from_rom, .fetch_waits, .read_waits,
		.write_waits, .operand_rdata, .done, .next_pc, .branch_taken, .operand_wr,
		.operand_wdata, .status_word, .interrupt_enable, .bank_select_bits, .wake,
		.halt_mode, .stop_mode);
	bbce_mem_model bbce_mem_model_inst (.clk, .load(ld), .load_data(ld_data), .operand_wr,
		.operand_wdata, .operand_rdata);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// -----
	// Tasks
	// -----
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// The operand byte is loaded one edge ahead so it is stable when the block takes it.
	task automatic run(input bbce_pkg::bbce_op_t op, input bbce_pkg::bbce_space_t sp,
			input logic [2:0] b, input logic f, input logic [3:0] fw, n, m,
			input logic [7:0] d, input int k, input logic [15:0] len, input logic tk);
		@(posedge clk);
		ld <= 1'b1;
		ld_data <= d;
		@(posedge clk);
		ld <= 1'b0;
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_space <= sp;
		instr_bit <= b;
		instr_fast_ram <= f;
		instr_from_rom <= fw == 4'h0;
		fetch_waits <= fw;
		read_waits <= n;
		write_waits <= m;
		@(posedge clk);
		instr_valid <= 1'b0;
		// The accept edge starts the count, so the first low-phase sample is not a cycle.
		cyc = 0;
		@(negedge clk);
		while (!done && cyc < 200) begin
			@(negedge clk);
			cyc++;
		end
		chk("done", done, 1'b1);
		if (k > 0)
			chk("cycles", cyc, k);
		chk("next_pc", next_pc, 16'(16'h1000 + len +
			(tk ? {{8{instr_offset[7]}}, instr_offset} : 16'h0000)));
		chk("branch", branch_taken, tk);
	endtask

	// -----
	// Tests
	// -----
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run(JS, SD, 3'h2, 1, 0, 0, 0, 8'h04, 8, 3, 1);
		run(JS, SD, 3'h2, 0, 0, 0, 0, 8'h04, 9, 3, 1);
		run(JS, bbce_pkg::SP_PERIPHERAL, 3'h7, 0, 0, 0, 0, 8'h7F, 11, 4, 0);
		run(JS, bbce_pkg::SP_ACCUMULATOR, 3'h6, 1, 0, 0, 0, 8'h40, 8, 3, 1);
		run(JS, PP, 3'h0, 0, 0, 3, 0, 8'h01, 14, 3, 1);
		run(JS, PP, 3'h0, 1, 0, 3, 0, 8'h01, 10, 3, 1);
		run(JC, SD, 3'h5, 1, 0, 0, 0, 8'hDF, 10, 4, 1);
		run(JC, bbce_pkg::SP_ACCUMULATOR, 3'h5, 1, 0, 0, 0, 8'h20, 8, 3, 0);
		run(JC, PS, 3'h1, 0, 0, 0, 0, 8'hFF, 11, 4, 1);
		run(JX, SD, 3'h3, 0, 0, 0, 0, 8'h0F, 12, 4, 1);
		@(negedge clk);
		chk("mem", operand_rdata, 8'h07);
		run(JX, SD, 3'h4, 1, 0, 0, 0, 8'h0F, 10, 4, 0);
		@(negedge clk);
		chk("mem", operand_rdata, 8'h0F);
		run(JX, PP, 3'h1, 0, 0, 2, 3, 8'h02, 17, 3, 1);
		wr(`BBCE_OFF_PSW, 32'h11);
		run(JX, PS, 3'h0, 0, 0, 0, 0, 8'h00, 12, 4, 1);
		chk("psw", status_word, 8'h10);
		run(DJ, bbce_pkg::SP_GENERAL_REG, 3'h0, 0, 0, 0, 0, 8'h01, 6, 2, 0);
		chk("dec", operand_wdata, 8'h00);
		@(posedge clk);
		instr_offset <= 8'h25;
		run(DJ, SD, 3'h0, 1, 0, 0, 0, 8'h05, 8, 3, 1);
		run(DJ, SD, 3'h0, 0, 0, 0, 0, 8'h05, 10, 3, 1);
		@(negedge clk);
		chk("mem", operand_rdata, 8'h04);
		run(bbce_pkg::OP_BANK_SWITCH, SD, 3'h0, 0, 0, 0, 0, 8'h00, 4, 2, 0);
		chk("bank", bank_select_bits, 2'h2);
		run(ID, SD, 3'h0, 0, 0, 0, 0, 8'h00, 2, 1, 0);
		run(ID, SD, 3'h0, 0, 3, 0, 0, 8'h00, 5, 1, 0);
		run(bbce_pkg::OP_UNMASK_INTERRUPTS, SD, 0, 0, 0, 0, 0, 0, 6, 2, 0);
		chk("ie", interrupt_enable, 1);
		run(bbce_pkg::OP_MASK_INTERRUPTS, SD, 0, 0, 0, 0, 0, 0, 6, 2, 0);
		chk("ie", interrupt_enable, 0);
		for (int i = 0; i < 2; i++) begin
			run(i ? bbce_pkg::OP_STOP : bbce_pkg::OP_HALT, SD, 0, 0, 0, 0, 0, 0, 6, 2, 0);
			@(negedge clk);
			chk("standby", {halt_mode, stop_mode, instr_ready}, i ? 3'b010 : 3'b100);
			@(posedge clk);
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			@(negedge clk);
			chk("woken", {halt_mode, stop_mode}, 2'b00);
		end
		wr(`BBCE_OFF_CLKSEL, 32'h7);
		rd(`BBCE_OFF_CLKSEL, rv);
		chk("clksel", rv, 32'h4);
		wr(`BBCE_OFF_CLKSEL, 32'h1);
		run(ID, SD, 3'h0, 0, 0, 0, 0, 8'h00, 0, 1, 0);
		chk("divided", cyc >= 3 && cyc <= 4, 1);
		wr(`BBCE_OFF_CLKSEL, 32'h0);
		rd(8'h0C, rv);
		chk("unmapped", rv, 32'h0);
		give_verdict();
	end

	// The whole sequence needs well under 2000 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule // testbench
